// ===== tscs_defines.vh
// Purpose: constants for the two-speed clock start-up block
// Assumes: core_clk at 250 MHz
// Notes:   offsets are word indices on the plain register port
`ifndef TSCS_DEFINES_VH
`define TSCS_DEFINES_VH
`define TSCS_ADDR_W        4
`define TSCS_OFF_CTRL      4'h0
`define TSCS_OFF_STAT      4'h1
`define TSCS_OFF_IRQ_STAT  4'h2
`define TSCS_OFF_IRQ_MASK  4'h3
`define TSCS_OFF_WARM      4'h4
// Control register fields
`define TSCS_CTRL_SCS_LSB  0
`define TSCS_CTRL_LPSLP    2
`define TSCS_CTRL_PLLEN    3
`define TSCS_CTRL_TARGET   6:4
`define TSCS_CTRL_RESET    8'h00
// Oscillator mode codes
`define TSCS_MODE_LP       3'h0
`define TSCS_MODE_XT       3'h1
`define TSCS_MODE_HS       3'h2
`define TSCS_MODE_EC       3'h3
`define TSCS_MODE_RC       3'h4
// Target source codes
`define TSCS_SRC_PRIMARY   3'h0
`define TSCS_SRC_LFINT     3'h1
`define TSCS_SRC_MFINT     3'h2
`define TSCS_SRC_HFINT     3'h3
`define TSCS_SRC_SOSC      3'h4
// Interrupt bits
`define TSCS_IRQ_DONE      0
`define TSCS_IRQ_ABORT     1
`define TSCS_IRQ_SWITCH    2
// Timing
`define TSCS_OST_COUNT     11'd1024
`define TSCS_EC_CYCLES     11'd2
`define TSCS_HFINT_NS      2000
`define TSCS_CLK_NS        4
`define TSCS_HFINT_CYC     (`TSCS_HFINT_NS / `TSCS_CLK_NS)
`define TSCS_PLL_NS        2000000
`define TSCS_PLL_CYC       (`TSCS_PLL_NS / `TSCS_CLK_NS)
`define TSCS_WARM_RESET    16'h0100
`endif

// ===== tscs_edge_sync.v
// Purpose: sample an oscillator level and flag each rising edge
// Assumes: input is asynchronous to core_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module tscs_edge_sync (
   input  wire core_clk,     // System clock
   input  wire resetn,       // Async reset, active low
   input  wire oscIn,        // Raw oscillator level
   output reg  oscRise_q     // One pulse per rising edge
);
   reg meta_q;
   reg sync_q;
   reg last_q;
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q    <= 1'b0;
         sync_q    <= 1'b0;
         last_q    <= 1'b0;
         oscRise_q <= 1'b0;
      end else begin
         meta_q    <= oscIn;
         sync_q    <= meta_q;
         last_q    <= sync_q;
         oscRise_q <= sync_q & ~last_q;
      end
   end
endmodule // tscs_edge_sync
`default_nettype wire

// ===== tscs_two_speed_startup.v
// Purpose: two-speed start-up, clock switch delays, low-power sleep control
// Assumes: oscillators are sampled on core_clk; the mux is driven by select outputs
// Notes:   on a switch, select outputs change only after both old and new clock idle low; wake sets them at once
// How it works
// - Crystal modes need 1024 external oscillations counted before use.
// - Non-crystal oscillator modes disable dual-speed start-up.
// - Count reaching 1024 while awake sets done flag and switches to external.
// - Sleep before qualification aborts the count; done flag stays clear.
// - Internal oscillator clocks the core during qualification.
// - Dual-speed needs switchover bit 1, select 00, crystal mode.
// - Dual-speed starts after power-on (post timer) and each wake.
// - Sleep or power-on to external clock or RC waits two cycles.
// - Low-freq internal to external clock or RC waits one cycle each.
// - Sleep or power-on to secondary or crystal waits 1024 counted cycles.
// - Switch to medium or high internal oscillator waits about 2 us; the logic counts 500 rises of the internal block clock instead.
// - Switch to 31 kHz internal oscillator waits one cycle of each.
// - Switch to 32 kHz secondary oscillator waits 1024 counted cycles.
// - Enabling the multiplier loop waits about 2 ms before use.
// - Low-power sleep select puts regulator in low power while asleep.
// - Waking with low-power sleep selected adds a regulator warm-up delay.
// - Default sleep mode wakes without the extra delay.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tscs_defines.vh"
module tscs_two_speed_startup #(
   parameter [20:0] PLL_WAIT = `TSCS_PLL_CYC   // Multiplier lock wait in cycles
) (
   input  wire                     core_clk,    // 250 MHz system clock
   input  wire                     resetn,      // Async reset, active low
   input  wire                     extOsc,      // External crystal/clock level
   input  wire                     sosc,        // Secondary oscillator level
   input  wire                     lfOsc,       // Low-freq internal osc level
   input  wire                     internal_oscillator_block,      // Internal block clock level
   input  wire [2:0]               oscModeCfg,  // Oscillator mode configuration
   input  wire                     switchEnCfg, // Switchover enable configuration
   input  wire                     pwrTimerDone,// Power-up timer expired
   input  wire                     sleepReq,    // Core executes sleep
   input  wire                     wakeReq,     // Wake-up event
   input  wire [`TSCS_ADDR_W-1:0]  regAddr,     // Register address
   input  wire [7:0]               regWdata,    // Write data
   input  wire                     regWr,       // Write strobe
   input  wire                     regRd,       // Read strobe
   output reg  [7:0]               regRdata_q,  // Read data, cycle after strobe
   output reg                      selExt_q,    // Mux select external source
   output reg                      selInt_q,    // Mux select internal source
   output reg                      coreRun_q,   // Core may execute
   output reg                      regLowPwr_q, // Regulator in low-power state
   output reg                      pllOn_q,     // Multiplier enabled
   output reg                      pllUse_q,    // Multiplied clock in use
   output reg                      irq_q        // Level interrupt
);
   localparam [5:0] S_POR   = 6'h01;
   localparam [5:0] S_RUN   = 6'h02;
   localparam [5:0] S_QUAL  = 6'h04;
   localparam [5:0] S_SWOLD = 6'h08;
   localparam [5:0] S_SWNEW = 6'h10;
   localparam [5:0] S_SLEEP = 6'h20;
   localparam [10:0] HF_WAIT = `TSCS_HFINT_CYC;

   reg  [5:0]  state_q;
   reg  [7:0]  ctrl_q;
   reg  [2:0]  irqStat_q;
   reg  [2:0]  irqMask_q;
   reg  [15:0] warm_q;
   reg  [10:0] ost_q;
   reg  [15:0] warmCnt_q;
   reg  [20:0] pllCnt_q;
   reg         doneFlag_q;
   reg         onExt_q;
   reg         wantExt_q;
   reg  [2:0]  curSrc_q;
   reg  [2:0]  tgtSrc_q;
   reg  [10:0] need_q;
   reg         fromSleep_q;
   reg         oldSeen_q;
   reg         pllEn_q;
   wire        extRise;
   wire        soscRise;
   wire        lfRise;
   wire        intRise;
   reg         srcRise;
   reg         curRise;
   reg  [2:0]  evt;

   tscs_edge_sync uExt (.core_clk(core_clk), .resetn(resetn), .oscIn(extOsc),
                        .oscRise_q(extRise));
   tscs_edge_sync uSosc (.core_clk(core_clk), .resetn(resetn), .oscIn(sosc),
                         .oscRise_q(soscRise));
   tscs_edge_sync uLf (.core_clk(core_clk), .resetn(resetn), .oscIn(lfOsc),
                       .oscRise_q(lfRise));
   tscs_edge_sync uInt (.core_clk(core_clk), .resetn(resetn), .oscIn(internal_oscillator_block),
                        .oscRise_q(intRise));

   wire crystal = (oscModeCfg == `TSCS_MODE_LP) || (oscModeCfg == `TSCS_MODE_XT) ||
                  (oscModeCfg == `TSCS_MODE_HS);
   wire [1:0] system_clock_select = ctrl_q[`TSCS_CTRL_SCS_LSB+1:`TSCS_CTRL_SCS_LSB];
   wire dualSpeed = switchEnCfg && (system_clock_select == 2'b00) && crystal;
   wire [2:0] tgtSel = ctrl_q[`TSCS_CTRL_TARGET];

   // Edge strobe of the source being brought up
   always @* begin
      case (tgtSrc_q)
         `TSCS_SRC_PRIMARY: srcRise = extRise;
         `TSCS_SRC_SOSC:    srcRise = soscRise;
         `TSCS_SRC_LFINT:   srcRise = lfRise;
         default:           srcRise = intRise;
      endcase
      case (curSrc_q)
         `TSCS_SRC_PRIMARY: curRise = onExt_q ? extRise : intRise;
         `TSCS_SRC_SOSC:    curRise = soscRise;
         `TSCS_SRC_LFINT:   curRise = lfRise;
         default:           curRise = intRise;
      endcase
   end

   // Delay needed for a requested switch
   function [10:0] switchWait;
      input [2:0] tgt;
      input       fromSlp;
      input [2:0] cur;
      begin
         case (tgt)
            `TSCS_SRC_SOSC:  switchWait = `TSCS_OST_COUNT;
            `TSCS_SRC_LFINT: switchWait = 11'd1;
            `TSCS_SRC_MFINT,
            `TSCS_SRC_HFINT: switchWait = HF_WAIT;
            default: begin
               if (crystal)
                  switchWait = `TSCS_OST_COUNT;
               else if (fromSlp)
                  switchWait = `TSCS_EC_CYCLES;
               else if (cur == `TSCS_SRC_LFINT)
                  switchWait = 11'd1;
               else
                  switchWait = `TSCS_EC_CYCLES;
            end
         endcase
      end
   endfunction

   always @* begin
      evt = 3'b000;
      evt[`TSCS_IRQ_DONE]   = (state_q == S_QUAL) && !sleepReq &&
                              (ost_q == `TSCS_OST_COUNT - 11'd1) && srcRise;
      evt[`TSCS_IRQ_ABORT]  = (state_q == S_QUAL) && sleepReq;
      evt[`TSCS_IRQ_SWITCH] = (state_q == S_SWNEW) && srcRise;
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= S_POR;
         ost_q       <= 11'h000;
         warmCnt_q   <= 16'h0000;
         doneFlag_q  <= 1'b0;
         onExt_q     <= 1'b0;
         wantExt_q   <= 1'b0;
         curSrc_q    <= `TSCS_SRC_HFINT;
         tgtSrc_q    <= `TSCS_SRC_HFINT;
         need_q      <= 11'h000;
         fromSleep_q <= 1'b1;
         oldSeen_q   <= 1'b0;
         selExt_q    <= 1'b0;
         selInt_q    <= 1'b1;
         coreRun_q   <= 1'b0;
         regLowPwr_q <= 1'b0;
      end else begin
         case (state_q)
            S_POR: begin
               if (pwrTimerDone) begin
                  if (warmCnt_q != 16'h0000) begin
                     warmCnt_q <= warmCnt_q - 16'h0001;
                  end else begin
                     regLowPwr_q <= 1'b0;
                     coreRun_q   <= 1'b1;
                     ost_q       <= 11'h000;
                     tgtSrc_q    <= `TSCS_SRC_PRIMARY;
                     if (dualSpeed) begin
                        state_q <= S_QUAL;
                     end else if (system_clock_select == 2'b00) begin
                        need_q      <= switchWait(`TSCS_SRC_PRIMARY, 1'b1, curSrc_q);
                        coreRun_q   <= 1'b0;
                        fromSleep_q <= 1'b1;
                        oldSeen_q   <= 1'b0;
                        state_q     <= S_SWOLD;
                     end else begin
                        state_q <= S_RUN;
                     end
                  end
               end
            end
            S_QUAL: begin
               if (sleepReq) begin
                  ost_q       <= 11'h000;
                  coreRun_q   <= 1'b0;
                  regLowPwr_q <= ctrl_q[`TSCS_CTRL_LPSLP];
                  state_q     <= S_SLEEP;
               end else if (!dualSpeed) begin
                  state_q <= S_RUN;
               end else if (srcRise) begin
                  ost_q <= ost_q + 11'd1;
                  if (ost_q == `TSCS_OST_COUNT - 11'd1) begin
                     doneFlag_q <= 1'b1;
                     wantExt_q  <= 1'b1;
                     oldSeen_q  <= 1'b0;
                     state_q    <= S_SWOLD;
                  end
               end
            end
            S_SWOLD: begin
               // Drop old select only after its clock rose, so it idles low
               if (curRise)
                  oldSeen_q <= 1'b1;
               if (oldSeen_q) begin
                  selInt_q <= 1'b0;
                  selExt_q <= 1'b0;
                  state_q  <= S_SWNEW;
                  ost_q    <= 11'h000;
               end
            end
            S_SWNEW: begin
               if (sleepReq && !doneFlag_q) begin
                  coreRun_q   <= 1'b0;
                  regLowPwr_q <= ctrl_q[`TSCS_CTRL_LPSLP];
                  state_q     <= S_SLEEP;
               end else if (srcRise && (wantExt_q || ost_q + 11'd1 >= need_q)) begin
                  selExt_q  <= (tgtSrc_q == `TSCS_SRC_PRIMARY);
                  selInt_q  <= (tgtSrc_q != `TSCS_SRC_PRIMARY);
                  onExt_q   <= (tgtSrc_q == `TSCS_SRC_PRIMARY);
                  curSrc_q  <= tgtSrc_q;
                  wantExt_q <= 1'b0;
                  coreRun_q <= 1'b1;
                  state_q   <= S_RUN;
               end else if (srcRise) begin
                  ost_q <= ost_q + 11'd1;
               end
            end
            S_RUN: begin
               if (sleepReq) begin
                  coreRun_q   <= 1'b0;
                  regLowPwr_q <= ctrl_q[`TSCS_CTRL_LPSLP];
                  state_q     <= S_SLEEP;
               end else if (tgtSel != curSrc_q) begin
                  tgtSrc_q    <= tgtSel;
                  need_q      <= switchWait(tgtSel, 1'b0, curSrc_q);
                  fromSleep_q <= 1'b0;
                  oldSeen_q   <= 1'b0;
                  state_q     <= S_SWOLD;
               end
            end
            S_SLEEP: begin
               doneFlag_q <= doneFlag_q & onExt_q;
               if (wakeReq) begin
                  // Extra wait only after a low-power sleep
                  warmCnt_q <= regLowPwr_q ? warm_q : 16'h0000;
                  onExt_q   <= 1'b0;
                  doneFlag_q<= 1'b0;
                  curSrc_q  <= `TSCS_SRC_HFINT;
                  selExt_q  <= 1'b0;
                  selInt_q  <= 1'b1;
                  state_q   <= S_POR;
               end
            end
            default: state_q <= S_POR;
         endcase
      end
   end

   // Multiplier lock wait
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pllEn_q  <= 1'b0;
         pllOn_q  <= 1'b0;
         pllUse_q <= 1'b0;
         pllCnt_q <= 21'h000000;
      end else begin
         pllEn_q <= ctrl_q[`TSCS_CTRL_PLLEN];
         pllOn_q <= ctrl_q[`TSCS_CTRL_PLLEN];
         if (!ctrl_q[`TSCS_CTRL_PLLEN]) begin
            pllCnt_q <= 21'h000000;
            pllUse_q <= 1'b0;
         end else if (pllEn_q && pllCnt_q < PLL_WAIT) begin
            pllCnt_q <= pllCnt_q + 21'd1;
         end else if (pllEn_q) begin
            pllUse_q <= 1'b1;
         end
      end
   end

   // Register port
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q     <= `TSCS_CTRL_RESET;
         irqStat_q  <= 3'b000;
         irqMask_q  <= 3'b000;
         warm_q     <= `TSCS_WARM_RESET;
         regRdata_q <= 8'h00;
         irq_q      <= 1'b0;
      end else begin
         // Hardware set wins over write-one clear
         if (regWr && regAddr == `TSCS_OFF_IRQ_STAT)
            irqStat_q <= (irqStat_q & ~regWdata[2:0]) | evt;
         else
            irqStat_q <= irqStat_q | evt;
         if (regWr && regAddr == `TSCS_OFF_CTRL)
            ctrl_q <= {1'b0, regWdata[6:0]};
         if (regWr && regAddr == `TSCS_OFF_IRQ_MASK)
            irqMask_q <= regWdata[2:0];
         if (regWr && regAddr == `TSCS_OFF_WARM)
            warm_q <= {8'h00, regWdata};
         irq_q <= |(irqStat_q & irqMask_q);
         regRdata_q <= 8'h00;
         if (regRd) begin
            case (regAddr)
               `TSCS_OFF_CTRL:     regRdata_q <= ctrl_q;
               `TSCS_OFF_STAT:     regRdata_q <= {2'b00, state_q[5:3] != 3'b000,
                                                  pllUse_q, selExt_q, dualSpeed,
                                                  onExt_q, doneFlag_q};
               `TSCS_OFF_IRQ_STAT: regRdata_q <= {5'b00000, irqStat_q};
               `TSCS_OFF_IRQ_MASK: regRdata_q <= {5'b00000, irqMask_q};
               `TSCS_OFF_WARM:     regRdata_q <= warm_q[7:0];
               default:            regRdata_q <= 8'h00;
            endcase
         end
      end
   end
endmodule // tscs_two_speed_startup
`default_nettype wire

// ===== tscs_checker.sv
// Purpose: port assertions for the two-speed start-up block
// Assumes: bound to tscs_two_speed_startup
// Notes:   PLL_WAIT follows the design parameter
`timescale 1ns/10ps
`default_nettype none
module tscs_checker #(
   parameter [20:0] PLL_WAIT = 21'd20        // Multiplier wait
) (
   input wire logic       core_clk,          // Clock
   input wire logic       resetn,            // Reset, active low
   input wire logic       extOsc,            // External osc level
   input wire logic [2:0] oscModeCfg,        // Osc mode
   input wire logic       pwrTimerDone,      // Power-up timer done
   input wire logic       sleepReq,          // Sleep request
   input wire logic       selExt_q,          // External selected
   input wire logic       selInt_q,          // Internal selected
   input wire logic       coreRun_q,         // Core runs
   input wire logic       regLowPwr_q,       // Regulator low power
   input wire logic       pllOn_q,           // Multiplier on
   input wire logic       pllUse_q           // Multiplier in use
);
   logic        extPrev_q;
   logic [11:0] extCnt_q;
   logic [21:0] pllCnt_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Raw external rises seen since last sleep or switch
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         extPrev_q <= 1'b0;
         extCnt_q <= 12'h000;
         pllCnt_q <= 22'h000000;
      end else begin
         extPrev_q <= extOsc;
         if (sleepReq || selExt_q)
            extCnt_q <= 12'h000;
         else if (extOsc && !extPrev_q && extCnt_q != 12'hfff)
            extCnt_q <= extCnt_q + 12'h001;
         if (!pllOn_q)
            pllCnt_q <= 22'h000000;
         else if (pllCnt_q != 22'h3fffff)
            pllCnt_q <= pllCnt_q + 22'h000001;
      end
   end
   sequence sExtRise;
      !selExt_q ##1 selExt_q;
   endsequence
   sequence sIntDrop;
      selInt_q ##1 !selInt_q;
   endsequence
   AST_ONE_SEL: assert property (!(selExt_q && selInt_q))
      else $error("both clock selects high");
   AST_GAP: assert property (sIntDrop |-> !selExt_q)
      else $error("no gap between clock selects");
   AST_XTAL_COUNT: assert property (sExtRise |-> oscModeCfg > 3'h2 || extCnt_q >= 12'd1024)
      else $error("external selected before full count");
   AST_SLEEP_ABORT: assert property (sleepReq && !selExt_q |=> !selExt_q)
      else $error("external selected after sleep");
   AST_LP_ASLEEP: assert property (regLowPwr_q |-> !coreRun_q)
      else $error("regulator low power while running");
   AST_RUN_POWER_UP_TIMER: assert property ($rose(coreRun_q) |-> pwrTimerDone)
      else $error("core ran before power-up timer");
   AST_PLL_WAIT: assert property ($rose(pllUse_q) |-> pllCnt_q >= PLL_WAIT)
      else $error("multiplied clock used too early");
   AST_PLL_OFF: assert property (!pllOn_q && !$past(pllOn_q) |-> !pllUse_q)
      else $error("multiplied clock used while off");
endmodule // tscs_checker
`default_nettype wire

// ===== tscs_osc_model.sv
// Purpose: free-running oscillator sources beside the block
// Assumes: crystal already oscillating after power-up
// Notes:   phases offset, unrelated to core_clk
`timescale 1ns/10ps
`default_nettype none
module tscs_osc_model #(
   parameter real EXT_HALF = 12.0,           // External half period
   parameter real INT_HALF = 8.0             // Internal half period
) (
   output var logic extOsc,                  // External crystal
   output var logic sosc,                    // Secondary osc
   output var logic lfOsc,                   // Low-freq internal
   output var logic internal_oscillator_block                   // Internal block
);
   initial begin
      extOsc = 1'b0;
      #5.3;
      forever #(EXT_HALF) extOsc = ~extOsc;
   end
   initial begin
      internal_oscillator_block = 1'b0;
      #1.7;
      forever #(INT_HALF) internal_oscillator_block = ~internal_oscillator_block;
   end
   initial begin
      sosc = 1'b0;
      forever #40.9 sosc = ~sosc;
   end
   initial begin
      lfOsc = 1'b0;
      forever #52.3 lfOsc = ~lfOsc;
   end
endmodule // tscs_osc_model
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the two-speed start-up block
// Assumes: PLL_WAIT shortened to 20
// Notes:   register port driven by tasks
`timescale 1ns/10ps
`default_nettype none
`include "tscs_defines.vh"
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR %0t %s", $time, m); end end
module tb_top;
   localparam [20:0] PLL_WAIT = 21'd20;
   logic       core_clk, resetn, extOsc, sosc, lfOsc, internal_oscillator_block;
   logic [2:0] oscModeCfg;
   logic       switchEnCfg, pwrTimerDone, sleepReq, wakeReq, regWr, regRd;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata_q;
   logic       selExt_q, selInt_q, coreRun_q, regLowPwr_q, pllOn_q, pllUse_q, irq_q;
   int         n_mismatch, n_compared, extRise, c, lat1;
   tscs_osc_model tscs_osc_model_inst (.extOsc(extOsc), .sosc(sosc), .lfOsc(lfOsc),
      .internal_oscillator_block(internal_oscillator_block));
   tscs_two_speed_startup #(.PLL_WAIT(PLL_WAIT)) tscs_two_speed_startup_inst (
      .core_clk(core_clk), .resetn(resetn), .extOsc(extOsc), .sosc(sosc),
      .lfOsc(lfOsc), .internal_oscillator_block(internal_oscillator_block), .oscModeCfg(oscModeCfg),
      .switchEnCfg(switchEnCfg), .pwrTimerDone(pwrTimerDone), .sleepReq(sleepReq),
      .wakeReq(wakeReq), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata_q(regRdata_q), .selExt_q(selExt_q),
      .selInt_q(selInt_q), .coreRun_q(coreRun_q), .regLowPwr_q(regLowPwr_q),
      .pllOn_q(pllOn_q), .pllUse_q(pllUse_q), .irq_q(irq_q));
   task automatic test_done;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] k, input logic [7:0] e,
                     input string m);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      `CHK(regRdata_q & k, e, m)
   endtask
   task automatic pulse(input logic s);
      @(posedge core_clk);
      if (s) sleepReq <= 1'b1;
      else wakeReq <= 1'b1;
      @(posedge core_clk);
      sleepReq <= 1'b0;
      wakeReq <= 1'b0;
   endtask
   function automatic logic sig(input int w);
      return w == 0 ? coreRun_q : w == 1 ? selExt_q : w == 2 ? pllUse_q : selInt_q;
   endfunction
   task automatic waitFor(input int w, input int lim, output int n);
      n = 0;
      while (n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
         if (sig(w) === 1'b1) break;
      end
      `CHK(sig(w), 1'b1, "wait ran out")
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge extOsc) extRise++;
   initial begin
      #100000;
      n_mismatch++;
      test_done;
   end
   initial begin
      resetn = 1'b0; oscModeCfg = `TSCS_MODE_XT; switchEnCfg = 1'b1;
      pwrTimerDone = 1'b0; sleepReq = 1'b0; wakeReq = 1'b0; regWr = 1'b0;
      regRd = 1'b0; regAddr = 4'h0; regWdata = 8'h00;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      #1;
      `CHK({selExt_q, selInt_q, coreRun_q, irq_q}, 4'b0100, "reset outputs")
      rd(`TSCS_OFF_CTRL, 8'hff, 8'h00, "ctrl reset");
      rd(`TSCS_OFF_WARM, 8'hff, 8'h00, "warm reset");
      wr(4'hf, 8'h5a);
      rd(4'hf, 8'hff, 8'h00, "unmapped");
      wr(`TSCS_OFF_CTRL, 8'h84);
      rd(`TSCS_OFF_CTRL, 8'hff, 8'h04, "ctrl top bit");
      wr(`TSCS_OFF_CTRL, 8'h00);
      wr(`TSCS_OFF_IRQ_MASK, 8'h07);
      rd(`TSCS_OFF_IRQ_MASK, 8'hff, 8'h07, "mask");
      `CHK(coreRun_q, 1'b0, "run before timer")
      $display("test reset done");
      extRise = 0;
      pwrTimerDone <= 1'b1;
      waitFor(0, 50, c);
      `CHK({selExt_q, selInt_q}, 2'b01, "internal during count")
      rd(`TSCS_OFF_STAT, 8'h05, 8'h04, "dual active");
      waitFor(1, 12000, c);
      `CHK(extRise >= 1024, 1'b1, "early switch")
      rd(`TSCS_OFF_STAT, 8'h0b, 8'h0b, "done flag");
      `CHK(irq_q, 1'b1, "done irq")
      rd(`TSCS_OFF_IRQ_STAT, 8'h01, 8'h01, "done status");
      wr(`TSCS_OFF_IRQ_STAT, 8'h07);
      rd(`TSCS_OFF_IRQ_STAT, 8'h07, 8'h00, "clear");
      `CHK(irq_q, 1'b0, "irq cleared")
      $display("test startup done");
      pulse(1'b1);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK({coreRun_q, regLowPwr_q}, 2'b00, "normal sleep")
      wr(`TSCS_OFF_WARM, 8'h40);
      pulse(1'b0);
      waitFor(0, 400, lat1);
      wr(`TSCS_OFF_CTRL, 8'h04);
      repeat (100) @(posedge core_clk);
      pulse(1'b1);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK({regLowPwr_q, selExt_q}, 2'b10, "low power sleep")
      rd(`TSCS_OFF_STAT, 8'h01, 8'h00, "abort flag");
      rd(`TSCS_OFF_IRQ_STAT, 8'h02, 8'h02, "abort irq");
      wr(`TSCS_OFF_IRQ_STAT, 8'h07);
      pulse(1'b0);
      waitFor(0, 2000, c);
      `CHK(c >= lat1 + 64, 1'b1, "warm-up")
      `CHK(regLowPwr_q, 1'b0, "regulator awake")
      $display("test sleep done");
      wr(`TSCS_OFF_CTRL, 8'h00);
      pulse(1'b1);
      oscModeCfg <= `TSCS_MODE_EC;
      pulse(1'b0);
      rd(`TSCS_OFF_STAT, 8'h04, 8'h00, "no dual in clock mode");
      waitFor(1, 100, c);
      $display("test clock mode done");
      wr(`TSCS_OFF_CTRL, 8'h08);
      waitFor(2, 100, c);
      `CHK(c >= PLL_WAIT && c <= PLL_WAIT + 4, 1'b1, "pll wait")
      `CHK(pllOn_q, 1'b1, "pll on")
      $display("test pll done");
      wr(`TSCS_OFF_IRQ_STAT, 8'h07);
      wr(`TSCS_OFF_CTRL, 8'h18);
      waitFor(3, 200, c);
      `CHK({selExt_q, selInt_q, coreRun_q}, 3'b011, "low-freq selected")
      rd(`TSCS_OFF_IRQ_STAT, 8'h04, 8'h04, "switch irq");
      $display("test source switch done");
      test_done;
   end
endmodule // tb_top
bind tscs_two_speed_startup tscs_checker #(.PLL_WAIT(PLL_WAIT)) tscs_checker_inst (
   .core_clk(core_clk), .resetn(resetn), .extOsc(extOsc), .oscModeCfg(oscModeCfg),
   .pwrTimerDone(pwrTimerDone), .sleepReq(sleepReq), .selExt_q(selExt_q),
   .selInt_q(selInt_q), .coreRun_q(coreRun_q), .regLowPwr_q(regLowPwr_q),
   .pllOn_q(pllOn_q), .pllUse_q(pllUse_q));
`default_nettype wire
